//--- logic/lqmr_top.sv
/*
  Link-quality monitor register bank: status snapshots, latched link-down
  causes, event counters, watchdog control and symbol polarity/order path.
  Assumes all event and status inputs come from logic on clk; register
  port is single-cycle, read data valid the cycle after the read strobe.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lqmr_regs.svh"
// Function
// RQ1: Last link training time in ms, read-only, low byte of its register.
// RQ2: Remote receiver ms in upper byte, local receiver ms in lower byte.
// RQ3: Bit 5 reads one until channel-ok drops; zero write re-arms it.
// RQ4: Bit 4 latches one on link-fail-inhibit until software writes zero.
// RQ5: Bit 3 latches one on training signal detect until zero write.
// RQ6: Bit 2 latches one on high frame error rate until zero write.
// RQ7: Bit 1 reads one until block lock lost; zero write re-arms.
// RQ8: Bit 0 reads one until watchdog reports low; zero write re-arms.
// RQ9: Six-bit read-only link-loss count in bits 15 to 10.
// RQ10: Ten-bit read-only link-fail-without-loss count in bits 9 to 0.
// RQ11: Read-only communication-ready flag at bit 0, rest reserved.
// RQ12: Sixteen-bit uncorrectable frame count, saturating, cleared when read.
// RQ13: Force enable bit 5 drives watchdog status to bit 6 value.
// RQ14: Watchdog enable bit 4 starts watchdog counters only after link up.
// RQ15: Watchdog stays deasserted when each symbol count meets the threshold; the code reports ok (1) in that case.
// RQ16: With bit 4, a follower's transmit polarity tracks received polarity.
// RQ17: Bit 3 reverses received symbol order S0 to S6.
// RQ18: Bit 2 inverts polarity of every received symbol.
// RQ19: Bit 1 reverses transmitted symbol order S0 to S6.
// RQ20: Bit 0 inverts polarity of every transmitted symbol.
// RQ21: Reserved bits read zero and ignore writes.
// RQ22: An event in the clearing write's cycle keeps the flag reporting.
module lqmr_top #(
  parameter int unsigned WD_WIN = `LQMR_WD_WIN
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [10:0] addr,
  input  wire logic [15:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [15:0] rd_data,
  input  wire logic [7:0]  train_time_ms,
  input  wire logic [7:0]  remote_rx_ms,
  input  wire logic [7:0]  local_rx_ms,
  input  wire logic        chan_good,
  input  wire logic        fail_inhibit,
  input  wire logic        training_sigdet,
  input  wire logic        high_frame_err,
  input  wire logic        blk_sync,
  input  wire logic        link_loss_evt,
  input  wire logic        link_fail_evt,
  input  wire logic        comm_ready,
  input  wire logic        uncorr_frame_evt,
  input  wire logic        link_up,
  input  wire logic        follower,
  input  wire logic        rx_pol_flipped,
  input  wire logic        rx_sym_vld,
  input  wire logic [13:0] rx_syms_in,
  input  wire logic [13:0] tx_syms_in,
  output logic      [13:0] rx_syms_out,
  output logic      [13:0] tx_syms_out,
  output logic             wd_status_ok
);
  logic [1:0]               rst_sync_r;
  logic                     rst_n_s;
  lqmr_pkg::lqmr_top_st_t   s_r;
  lqmr_pkg::lqmr_top_st_t   s_nxt;
  logic                     wd_raw_ok;
  logic                     wd_run;
  logic                     wr_latch;
  logic                     rd_unc;
  logic [5:0]               evt;
  // Latch-low positions as a vector, so each bit is picked rather than shifted
  localparam logic [5:0]    LL_MASK = `LQMR_LL_MASK;

  //////////////////////////////////////////////////////////////////////
  // Functions

  // Saturating increment shared by all counters
  function automatic logic [15:0] sat_inc(
    input logic [15:0] v,
    input logic [15:0] vmax
  );
    sat_inc = (v >= vmax) ? vmax : v + 16'h0001;
  endfunction : sat_inc

  // Negate a ternary symbol
  function automatic lqmr_pkg::lqmr_sym_t sym_neg(
    input lqmr_pkg::lqmr_sym_t v
  );
    sym_neg = ~v + 2'h1;
  endfunction : sym_neg

  // Optional order reversal then optional polarity inversion of S0..S6
  function automatic logic [13:0] sym_xform(
    input logic [13:0] v,
    input logic        rev,
    input logic        inv
  );
    lqmr_pkg::lqmr_sym_t src;
    sym_xform = '0;
    for (int i = 0; i < 7; i++) begin
      src = rev ? v[2*(6-i) +: 2] : v[2*i +: 2];
      sym_xform[2*i +: 2] = inv ? sym_neg(src) : src;
    end
  endfunction : sym_xform

  //////////////////////////////////////////////////////////////////////
  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n_s = rst_sync_r[1];

  //////////////////////////////////////////////////////////////////////
  // Decodes and event vector for the latch register
  assign wr_latch = wr_en && addr == `LQMR_OFF_LATCH;
  assign rd_unc   = rd_en && addr == `LQMR_OFF_UNCORR;
  // Latch-low bits see the drop of their condition as the event
  always_comb begin
    evt = '0;
    evt[`LQMR_B_CHAN]   = !chan_good;
    evt[`LQMR_B_INHIB]  = fail_inhibit;
    evt[`LQMR_B_SIGDET] = training_sigdet;
    evt[`LQMR_B_HIFER]  = high_frame_err;
    evt[`LQMR_B_BLK]    = !blk_sync;
    evt[`LQMR_B_WD]     = !s_r.wd_ok;
  end

  // Watchdog counters gated by link up only when enabled
  assign wd_run = s_r.wdc[`LQMR_B_WDEN] ? link_up : 1'b1; // [RQ14]

  lqmr_sym_wd #(
    .WIN_LEN (WD_WIN)
  ) u_wd (
    .clk     (clk),
    .rst_n   (rst_n_s),
    .run     (wd_run),
    .sym_vld (rx_sym_vld),
    .sym     (rx_syms_in[1:0]),
    .thr     (s_r.wdc[3:0]),
    .wd_ok   (wd_raw_ok)
  );

  //////////////////////////////////////////////////////////////////////
  // Next state of the whole bank
  always_comb begin
    logic tx_inv;
    tx_inv = 1'b0;
    s_nxt = s_r;
    // Status snapshots follow the core every cycle
    s_nxt.train = train_time_ms; // [RQ1]
    s_nxt.rrx   = remote_rx_ms;  // [RQ2]
    s_nxt.lrx   = local_rx_ms;   // [RQ2]
    s_nxt.comm  = comm_ready;    // [RQ11]

    // Zero write clears latch-high, re-arms latch-low; event applied last
    for (int b = 0; b < 6; b++) begin
      if (wr_latch && !wr_data[b]) begin
        s_nxt.latch[b] = LL_MASK[b]; // [RQ3] [RQ7] [RQ8]
      end
      if (evt[b]) begin
        s_nxt.latch[b] = !LL_MASK[b]; // [RQ4] [RQ5] [RQ6] [RQ22]
      end
    end

    // Lifetime counters hold at their maximum rather than wrap
    if (link_loss_evt) begin
      s_nxt.loss = 6'(sat_inc(16'(s_r.loss), `LQMR_LOSS_MAX)); // [RQ9]
    end
    if (link_fail_evt) begin
      s_nxt.fail = 10'(sat_inc(16'(s_r.fail), `LQMR_FAIL_MAX)); // [RQ10]
    end

    // Read clears; a frame in the read cycle is kept as the new count
    if (rd_unc) begin
      s_nxt.unc = '0; // [RQ12]
    end
    if (uncorr_frame_evt) begin
      s_nxt.unc = rd_unc ? 16'h0001 : sat_inc(s_r.unc, `LQMR_UNC_MAX); // [RQ12] [RQ22]
    end

    // Writable fields; reserved bits are simply not stored
    if (wr_en) begin
      case (addr)
        `LQMR_OFF_WDCTL:  s_nxt.wdc = wr_data[6:0]; // [RQ21]
        `LQMR_OFF_SYMCFG: s_nxt.sym = wr_data[4:0];
        `LQMR_OFF_OAM:    s_nxt.oam = wr_data[1:0];
        default: ;
      endcase
    end

    // Read data stands one cycle only; unmapped reads give zero
    s_nxt.rd_data = '0;
    if (rd_en) begin
      case (addr)
        `LQMR_OFF_TRAIN:  s_nxt.rd_data = {8'h00, s_r.train}; // [RQ1] [RQ21]
        `LQMR_OFF_RXTIME: s_nxt.rd_data = {s_r.rrx, s_r.lrx}; // [RQ2]
        `LQMR_OFF_LATCH:  s_nxt.rd_data = {10'h000, s_r.latch};
        `LQMR_OFF_EVCNT:  s_nxt.rd_data = {s_r.loss, s_r.fail}; // [RQ9] [RQ10]
        `LQMR_OFF_COMM:   s_nxt.rd_data = {15'h0000, s_r.comm}; // [RQ11]
        `LQMR_OFF_UNCORR: s_nxt.rd_data = s_r.unc; // [RQ12]
        `LQMR_OFF_WDCTL:  s_nxt.rd_data = {9'h000, s_r.wdc};
        `LQMR_OFF_SYMCFG: s_nxt.rd_data = {11'h000, s_r.sym};
        `LQMR_OFF_OAM:    s_nxt.rd_data = {14'h0000, s_r.oam};
        default:          s_nxt.rd_data = '0;
      endcase
    end

    // Forced value overrides the counted watchdog status
    s_nxt.wd_ok = s_r.wdc[`LQMR_B_FEN] ? s_r.wdc[`LQMR_B_FVAL] : wd_raw_ok; // [RQ13]

    // Follower may track the detected receive polarity on transmit
    tx_inv = s_r.sym[`LQMR_B_TXPOL] ^ (s_r.sym[`LQMR_B_FOLLOW] && follower
             && rx_pol_flipped); // [RQ16] [RQ20]
    s_nxt.tx = sym_xform(tx_syms_in, s_r.sym[`LQMR_B_TXORD], tx_inv); // [RQ19]
    s_nxt.rx = sym_xform(rx_syms_in, s_r.sym[`LQMR_B_RXORD],
                         s_r.sym[`LQMR_B_RXPOL]); // [RQ17] [RQ18]
  end

  // State register; only the watchdog control has non-zero reset
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      s_r     <= '0;
      s_r.wdc <= `LQMR_WDC_RST; // [RQ13] [RQ14] [RQ15]
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rd_data      = s_r.rd_data;
  assign rx_syms_out  = s_r.rx;
  assign tx_syms_out  = s_r.tx;
  assign wd_status_ok = s_r.wd_ok;

  //////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_s);

  sequence rd_unc_s;
    rd_unc && !uncorr_frame_evt;
  endsequence
  sequence unc_sat_s;
    s_r.unc == `LQMR_UNC_MAX && uncorr_frame_evt && !rd_unc;
  endsequence
  sequence clr_inhib_s;
    wr_latch && !wr_data[`LQMR_B_INHIB] && fail_inhibit;
  endsequence

  unc_rc_a: assert property (rd_unc_s |=> s_r.unc == 16'h0000 // [RQ12]
    && rd_data == $past(s_r.unc))
    else $error("uncorrectable count not cleared on read");
  unc_sat_a: assert property (unc_sat_s |=> s_r.unc == `LQMR_UNC_MAX) // [RQ12]
    else $error("uncorrectable count wrapped");
  comm_read_a: assert property (rd_en && addr == `LQMR_OFF_COMM // [RQ11]
    |=> rd_data == {15'h0000, $past(comm_ready, 2)})
    else $error("comm ready read wrong");
  inhib_wins_a: assert property (clr_inhib_s |=> s_r.latch[`LQMR_B_INHIB]) // [RQ22]
    else $error("clear beat a fail inhibit event");
  sigdet_hold_a: assert property (s_r.latch[`LQMR_B_SIGDET] // [RQ5]
    && !(wr_latch && !wr_data[`LQMR_B_SIGDET]) |=> s_r.latch[`LQMR_B_SIGDET])
    else $error("sigdet latch dropped without clear");
  hifer_set_a: assert property (high_frame_err ##1 !high_frame_err // [RQ6]
    |-> s_r.latch[`LQMR_B_HIFER])
    else $error("frame error latch not set");
  chan_drop_a: assert property (!chan_good |=> !s_r.latch[`LQMR_B_CHAN]) // [RQ3]
    else $error("channel latch not cleared by drop");
  blk_rearm_a: assert property (wr_latch && !wr_data[`LQMR_B_BLK] // [RQ7]
    && blk_sync |=> s_r.latch[`LQMR_B_BLK])
    else $error("block lock latch not re-armed");
  wd_force_a: assert property (s_r.wdc[`LQMR_B_FEN] ##1 s_r.wdc[`LQMR_B_FEN] // [RQ13]
    |-> wd_status_ok == $past(s_r.wdc[`LQMR_B_FVAL]))
    else $error("watchdog force ignored");
  loss_cnt_a: assert property (link_loss_evt // [RQ9]
    && 16'(s_r.loss) != `LQMR_LOSS_MAX |=> s_r.loss == $past(s_r.loss) + 6'h01)
    else $error("link loss count wrong");
  tx_pol_a: assert property (s_r.sym == 5'h01 // [RQ20]
    |=> tx_syms_out[1:0] == sym_neg($past(tx_syms_in[1:0])))
    else $error("transmit polarity not inverted");
  rx_ord_a: assert property (s_r.sym == 5'h08 // [RQ17]
    |=> rx_syms_out[1:0] == $past(rx_syms_in[13:12]))
    else $error("receive order not reversed");

  // Latch-high causes set on their event, latch-low ones drop with their condition
  inhib_set_a: assert property (fail_inhibit |=> s_r.latch[`LQMR_B_INHIB]) // [RQ4]
    else $error("fail inhibit latch not set");
  sigdet_set_a: assert property (training_sigdet |=> s_r.latch[`LQMR_B_SIGDET]) // [RQ5]
    else $error("sigdet latch not set");
  blk_drop_a: assert property (!blk_sync |=> !s_r.latch[`LQMR_B_BLK]) // [RQ7]
    else $error("block lock latch not cleared by loss");
  wd_drop_a: assert property (!wd_status_ok |=> !s_r.latch[`LQMR_B_WD]) // [RQ8]
    else $error("watchdog latch not cleared by low status");

  // Fail count steps by one; loss count sticks at its ceiling
  sequence fail_step_s;
    link_fail_evt && 16'(s_r.fail) != `LQMR_FAIL_MAX;
  endsequence
  sequence loss_full_s;
    link_loss_evt && 16'(s_r.loss) == `LQMR_LOSS_MAX;
  endsequence
  fail_cnt_a: assert property (fail_step_s // [RQ10]
    |=> s_r.fail == $past(s_r.fail) + 10'h001)
    else $error("link fail count wrong");
  loss_sat_a: assert property (loss_full_s |=> 16'(s_r.loss) == `LQMR_LOSS_MAX) // [RQ9]
    else $error("link loss count wrapped");

  // Snapshot reads return the input from two cycles before the answer
  sequence rd_train_s;
    rd_en && addr == `LQMR_OFF_TRAIN;
  endsequence
  sequence rd_rxtime_s;
    rd_en && addr == `LQMR_OFF_RXTIME;
  endsequence
  train_read_a: assert property (rd_train_s // [RQ1]
    |=> rd_data == {8'h00, $past(train_time_ms, 2)})
    else $error("training time read wrong");
  rxtime_read_a: assert property (rd_rxtime_s // [RQ2]
    |=> rd_data == {$past(remote_rx_ms, 2), $past(local_rx_ms, 2)})
    else $error("receiver time read wrong");
  // Read data is zero outside its one answer cycle; reserved bits stay zero
  rd_idle_a: assert property (!rd_en |=> rd_data == 16'h0000) // [RQ21]
    else $error("read data outside answer cycle");
  resv_read_a: assert property (rd_en && addr == `LQMR_OFF_LATCH // [RQ21]
    |=> rd_data[15:6] == 10'h000)
    else $error("reserved latch bits not zero");

  // Gated-off watchdog reports healthy while the link is still down
  wd_idle_a: assert property (s_r.wdc[`LQMR_B_WDEN] && !link_up |=> wd_raw_ok) // [RQ14]
    else $error("watchdog ran before link up");

  // Remaining symbol path settings, one at a time
  rx_pol_a: assert property (s_r.sym == 5'h04 // [RQ18]
    |=> rx_syms_out[1:0] == sym_neg($past(rx_syms_in[1:0])))
    else $error("receive polarity not inverted");
  tx_ord_a: assert property (s_r.sym == 5'h02 // [RQ19]
    |=> tx_syms_out[1:0] == $past(tx_syms_in[13:12]))
    else $error("transmit order not reversed");
  tx_follow_a: assert property (s_r.sym == 5'h10 && follower && rx_pol_flipped // [RQ16]
    |=> tx_syms_out[1:0] == sym_neg($past(tx_syms_in[1:0])))
    else $error("follower transmit polarity not tracked");
endmodule : lqmr_top
`default_nettype wire

//--- logic/lqmr_regs.svh
/*
  Register offsets, field positions, reset values and limits of the
  link-quality monitor register bank.
  Assumes an 11-bit word address on the management register port.
*/
`ifndef LQMR_REGS_SVH
`define LQMR_REGS_SVH
// Word offsets in the management register space
`define LQMR_OFF_TRAIN  11'h543
`define LQMR_OFF_RXTIME 11'h544
`define LQMR_OFF_LATCH  11'h545
`define LQMR_OFF_EVCNT  11'h547
`define LQMR_OFF_COMM   11'h548
`define LQMR_OFF_UNCORR 11'h552
`define LQMR_OFF_WDCTL  11'h559
`define LQMR_OFF_SYMCFG 11'h55B
`define LQMR_OFF_OAM    11'h55C
// Latch bits; the mask marks the latch-low ones (5, 1, 0)
`define LQMR_B_CHAN     5
`define LQMR_B_INHIB    4
`define LQMR_B_SIGDET   3
`define LQMR_B_HIFER    2
`define LQMR_B_BLK      1
`define LQMR_B_WD       0
`define LQMR_LL_MASK    6'h23
// Watchdog control fields
`define LQMR_B_FVAL     6
`define LQMR_B_FEN      5
`define LQMR_B_WDEN     4
`define LQMR_WDC_RST    7'h51
// Symbol polarity and order fields
`define LQMR_B_FOLLOW   4
`define LQMR_B_RXORD    3
`define LQMR_B_RXPOL    2
`define LQMR_B_TXORD    1
`define LQMR_B_TXPOL    0
// Counter limits and symbol watchdog window
`define LQMR_LOSS_MAX   16'h003F
`define LQMR_FAIL_MAX   16'h03FF
`define LQMR_UNC_MAX    16'hFFFF
`define LQMR_THR_MAX    4'hF
`define LQMR_WD_WIN     64
`endif

//--- logic/lqmr_pkg.sv
/*
  Types shared by the link-quality monitor register bank.
  Assumes lqmr_regs.svh for field positions; holds no logic.
*/
`default_nettype none
package lqmr_pkg;
  // One ternary symbol: 00 zero, 01 plus one, 11 minus one
  typedef logic [1:0] lqmr_sym_t;

  // Whole state of the register bank
  typedef struct packed {
    logic [15:0] rd_data;
    logic [5:0]  latch;
    logic [5:0]  loss;
    logic [9:0]  fail;
    logic [15:0] unc;
    logic [6:0]  wdc;
    logic [4:0]  sym;
    logic [1:0]  oam;
    logic [7:0]  train;
    logic [7:0]  rrx;
    logic [7:0]  lrx;
    logic        comm;
    logic [13:0] tx;
    logic [13:0] rx;
    logic        wd_ok;
  } lqmr_top_st_t;

  // Whole state of the symbol watchdog
  typedef struct packed {
    logic [2:0][3:0] cnt;
    logic [7:0]      win;
    logic            ok;
  } lqmr_wd_st_t;
endpackage : lqmr_pkg
`default_nettype wire

//--- logic/lqmr_sym_wd.sv
/*
  Symbol watchdog: counts zero, plus-one and minus-one symbols per window
  and reports ok while each count reached the threshold in the last one.
  Assumes symbols and control arrive on clk; rst_n is already synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lqmr_regs.svh"
module lqmr_sym_wd #(
  parameter int unsigned WIN_LEN = `LQMR_WD_WIN
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             run,
  input  wire logic             sym_vld,
  input  wire lqmr_pkg::lqmr_sym_t sym,
  input  wire logic [3:0]       thr,
  output logic                  wd_ok
);
  lqmr_pkg::lqmr_wd_st_t s_r;
  lqmr_pkg::lqmr_wd_st_t s_nxt;

  // Symbol code watched by counter i
  function automatic lqmr_pkg::lqmr_sym_t sym_code(input int i);
    sym_code = (i == 0) ? 2'h0 : ((i == 1) ? 2'h1 : 2'h3);
  endfunction : sym_code

  //////////////////////////////////////////////////////////////////////
  // Count per window; idle counters report ok so no false alarm
  always_comb begin
    logic all_met;
    all_met = 1'b1;
    s_nxt = s_r;
    if (!run) begin
      s_nxt.cnt = '0;
      s_nxt.win = '0;
      s_nxt.ok  = 1'b1;
    end else if (sym_vld) begin
      for (int i = 0; i < 3; i++) begin
        if (sym == sym_code(i) && s_r.cnt[i] != `LQMR_THR_MAX) begin
          s_nxt.cnt[i] = s_r.cnt[i] + 4'h1;
        end
      end
      for (int i = 0; i < 3; i++) begin
        if (s_nxt.cnt[i] < thr) begin
          all_met = 1'b0;
        end
      end
      if (s_r.win == 8'(WIN_LEN - 1)) begin
        s_nxt.ok  = all_met; // [RQ15]
        s_nxt.cnt = '0;
        s_nxt.win = '0;
      end else begin
        s_nxt.win = s_r.win + 8'h01;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.ok <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wd_ok = s_r.ok;
endmodule : lqmr_sym_wd
`default_nettype wire

//--- verification/lqmr_partner.sv
/*
  Link partner model: drives the receive symbol stream toward the bank.
  Assumes clk from the bench; the bench picks the traffic mode.
*/
`timescale 1ns/1ps
`default_nettype none
module lqmr_partner (
  input  wire logic        clk,
  input  wire logic [1:0]  mode,
  output logic      [13:0] rx_syms,
  output logic             rx_vld
);
  logic [31:0] s_r  = 32'h0000_0005;
  logic [13:0] sy_r = 14'h0000;
  logic        v_r  = 1'b0;
  int          k_r  = 0;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // Only legal codes: 00 zero, 01 plus one, 11 minus one
  function automatic logic [1:0] cs(input int v);
    return (v == 0) ? 2'h0 : (v == 1) ? 2'h1 : 2'h3;
  endfunction : cs

  // Mode 0 random and gappy, 1 all zero, 2 rotating 0,+1,-1
  always_ff @(posedge clk) begin
    s_r <= xs(s_r);
    k_r <= (k_r + 1) % 3;
    v_r <= (mode != 2'h0) | s_r[9];
    for (int i = 0; i < 7; i++) begin
      sy_r[2*i +: 2] <= (mode == 2'h1) ? 2'h0 : (mode == 2'h2) ? cs(k_r) : cs(s_r[4*i +: 4] % 3);
    end
  end

  assign rx_syms = sy_r;
  assign rx_vld  = v_r;
endmodule : lqmr_partner
`default_nettype wire

//--- verification/tb.sv
/*
  Self-checking bench for the link-quality monitor register bank.
  Assumes lqmr_top with a short watchdog window and the partner model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lqmr_regs.svh"
module tb;
  logic        clk = 1'b0, arst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  logic [10:0] addr = 11'h000;
  logic [15:0] wr_data = 16'h0000, rd_data;
  logic [7:0]  trn = 8'h00, rrx = 8'h00, lrx = 8'h00;
  logic        chan_good = 1'b1, blk = 1'b1, comm = 1'b0, link_up = 1'b0;
  logic [5:0]  ev = 6'h00;
  logic        unc = 1'b0, follower = 1'b0, polf = 1'b0, rx_vld, wd_ok;
  logic [13:0] rx_in, tx_in = 14'h0000, rx_out, tx_out, cr, ct;
  logic [1:0]  mode = 2'h0;
  logic [31:0] seed = 32'h0000_0021;
  int          failures = 0, samples_checked = 0;
  localparam logic [10:0] OFFS [10] = '{`LQMR_OFF_TRAIN, `LQMR_OFF_RXTIME, `LQMR_OFF_LATCH,
    `LQMR_OFF_EVCNT, `LQMR_OFF_COMM, `LQMR_OFF_UNCORR, `LQMR_OFF_WDCTL, `LQMR_OFF_SYMCFG,
    `LQMR_OFF_OAM, 11'h546};
  localparam logic [15:0] RSTV [10] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0051, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] ONES [10] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h007F, 16'h001F, 16'h0003, 16'h0000};

  // Free-running 250 MHz clock
  initial forever #2 clk = ~clk;

  lqmr_top #(.WD_WIN(8)) dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .train_time_ms(trn),
    .remote_rx_ms(rrx), .local_rx_ms(lrx), .chan_good(chan_good), .fail_inhibit(ev[3]),
    .training_sigdet(ev[4]), .high_frame_err(ev[5]), .blk_sync(blk),
    .link_loss_evt(ev[0]), .link_fail_evt(ev[1]), .comm_ready(comm),
    .uncorr_frame_evt(unc | ev[2]), .link_up(link_up), .follower(follower),
    .rx_pol_flipped(polf), .rx_sym_vld(rx_vld), .rx_syms_in(rx_in), .tx_syms_in(tx_in),
    .rx_syms_out(rx_out), .tx_syms_out(tx_out), .wd_status_ok(wd_ok));

  lqmr_partner peer (.clk(clk), .mode(mode), .rx_syms(rx_in), .rx_vld(rx_vld));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Illegal code 10 folded to zero so stimulus stays legal
  function automatic logic [13:0] lg(input logic [31:0] v);
    for (int i = 0; i < 7; i++) begin
      if (v[2*i +: 2] == 2'h2) v[2*i +: 2] = 2'h0;
    end
    return v[13:0];
  endfunction : lg

  // Reference symbol transform: reverse then negate
  function automatic logic [13:0] xf(input logic [13:0] v, input logic rev, input logic inv);
    logic [13:0] o;
    for (int i = 0; i < 7; i++) begin
      o[2*i +: 2] = rev ? v[2*(6-i) +: 2] : v[2*i +: 2];
      if (inv && o[2*i +: 2] != 2'h0) o[2*i +: 2] = o[2*i +: 2] ^ 2'h2;
    end
    return o;
  endfunction : xf

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [10:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  // Read data only stands in the cycle after the strobe
  task automatic rd(input logic [10:0] a, input logic [15:0] exp);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    chk(rd_data, exp);
    @(posedge clk);
  endtask : rd

  // Spaced one-cycle pulses on one event line
  task automatic pulse(input int w, input int n);
    repeat (n) begin
      @(posedge clk);
      ev[w] <= 1'b1;
      @(posedge clk);
      ev[w] <= 1'b0;
    end
  endtask : pulse

  task automatic close_out();
    $display("Checked %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  // Hang guard, well past the longest sequence
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      rd(OFFS[i], RSTV[i]);
      wr(OFFS[i], 16'hFFFF);
      rd(OFFS[i], ONES[i]);
    end
    wr(`LQMR_OFF_WDCTL, 16'h0051);
    // Status snapshots
    trn  <= 8'(rnd());
    rrx  <= 8'(rnd());
    lrx  <= 8'(rnd());
    comm <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`LQMR_OFF_TRAIN, {8'h00, trn});
    rd(`LQMR_OFF_RXTIME, {rrx, lrx});
    rd(`LQMR_OFF_COMM, 16'h0001);
    // Latches: re-arm, set, knock down, then clear racing an event
    wr(`LQMR_OFF_LATCH, 16'h0000);
    rd(`LQMR_OFF_LATCH, 16'h0023);
    pulse(3, 1);
    pulse(4, 1);
    pulse(5, 1);
    rd(`LQMR_OFF_LATCH, 16'h003F);
    chan_good <= 1'b0;
    blk       <= 1'b0;
    @(posedge clk);
    chan_good <= 1'b1;
    blk       <= 1'b1;
    wr(`LQMR_OFF_WDCTL, 16'h0031);
    // Forced value shows one cycle after the write lands
    @(negedge clk);
    @(negedge clk);
    chk({15'h0, wd_ok}, 16'h0000);
    rd(`LQMR_OFF_LATCH, 16'h001C);
    wr(`LQMR_OFF_WDCTL, 16'h0051);
    ev[3] <= 1'b1;
    wr(`LQMR_OFF_LATCH, 16'h0000);
    ev[3] <= 1'b0;
    rd(`LQMR_OFF_LATCH, 16'h0033);
    // Counters, loss past its ceiling
    pulse(0, 70);
    pulse(1, 5);
    rd(`LQMR_OFF_EVCNT, {6'h3F, 10'd5});
    pulse(2, 3);
    rd(`LQMR_OFF_UNCORR, 16'h0003);
    rd(`LQMR_OFF_UNCORR, 16'h0000);
    unc <= 1'b1;
    repeat (65540) @(posedge clk);
    unc <= 1'b0;
    rd(`LQMR_OFF_UNCORR, 16'hFFFF);
    rd(`LQMR_OFF_UNCORR, 16'h0000);
    // Every polarity/order setting against random legal symbols
    for (int i = 0; i < 128; i++) begin
      wr(`LQMR_OFF_SYMCFG, 16'(i[4:0]));
      follower <= i[5];
      polf     <= i[6];
      repeat (3) begin
        @(posedge clk);
        cr = rx_in;
        ct = tx_in;
        tx_in <= lg(rnd());
        @(negedge clk);
        chk({2'h0, rx_out}, {2'h0, xf(cr, i[3], i[2])});
        chk({2'h0, tx_out}, {2'h0, xf(ct, i[1], i[0] ^ (i[4] & i[5] & i[6]))});
      end
    end
    // Symbol watchdog: gated by link up, threshold edge, force
    @(posedge clk);
    mode <= 2'h1;
    repeat (40) @(posedge clk);
    chk({15'h0, wd_ok}, 16'h0001);
    link_up <= 1'b1;
    repeat (40) @(posedge clk);
    chk({15'h0, wd_ok}, 16'h0000);
    wr(`LQMR_OFF_WDCTL, 16'h0071);
    repeat (3) @(posedge clk);
    chk({15'h0, wd_ok}, 16'h0001);
    mode <= 2'h2;
    wr(`LQMR_OFF_WDCTL, 16'h0052);
    repeat (40) @(posedge clk);
    chk({15'h0, wd_ok}, 16'h0001);
    wr(`LQMR_OFF_WDCTL, 16'h0053);
    repeat (40) @(posedge clk);
    chk({15'h0, wd_ok}, 16'h0000);
    close_out();
  end
endmodule : tb
`default_nettype wire
